// ---- verilog/tspc_pkg.sv ----
// Notes on behaviour
// RL1: Mode 10 with function 11 selects single pulse
// RL2: Run bit rising edge triggers pulse start
// RL3: External clock pin edge sets run bit
// RL4: Run high starts counter and pulse together
// RL5: Run bit falling ends the pulse
// RL6: Compare A match clears run, interrupts
// RL7: Counter zeroed only on run rising edge; code loads 1 there instead
// RL8: Single pulse ignores P, clear, swap
// RL9: Software holds run and function field steady
// RL10: Mode 01 selects capture input
// RL11: Function field picks edge; 11 disables capture
// RL12: Capture counter starts on run rising edge
// RL13: Active edge copies counter into compare A
// RL14: Capture counter runs until run falls
// RL15: Compare P match zeroes counter, interrupts
// RL16: Pin edges capture even when driven out
// RL17: Capture ignores level, invert, clear, swap
// RL18: P compares top byte; zero means 65536
// RL19: Pins synchronised, one event per edge
package tspc_pkg;

  // Register byte offsets
  localparam logic [4:0] TSPC_OFS_CTRL    = 5'h00;
  localparam logic [4:0] TSPC_OFS_RUN     = 5'h04;
  localparam logic [4:0] TSPC_OFS_CMPA    = 5'h08;
  localparam logic [4:0] TSPC_OFS_CMPP    = 5'h0C;
  localparam logic [4:0] TSPC_OFS_COUNT   = 5'h10;
  localparam logic [4:0] TSPC_OFS_STATUS  = 5'h14;
  localparam logic [4:0] TSPC_OFS_MASK    = 5'h18;

  // Control field positions
  localparam int TSPC_POS_CLR   = 0;
  localparam int TSPC_POS_CAPTS = 1;
  localparam int TSPC_POS_INV   = 2;
  localparam int TSPC_POS_LEVEL = 3;
  localparam int TSPC_POS_FUNC  = 4;
  localparam int TSPC_POS_MODE  = 6;
  localparam int TSPC_POS_SWAP  = 8;

  // Status bit positions
  localparam int TSPC_ST_A = 0;
  localparam int TSPC_ST_P = 1;

  // Mode and function codes
  localparam logic [1:0] TSPC_MODE_CAPTURE = 2'h1;
  localparam logic [1:0] TSPC_MODE_PULSE   = 2'h2;
  localparam logic [1:0] TSPC_FUNC_SINGLE  = 2'h3;
  localparam logic [1:0] TSPC_CAP_RISE     = 2'h0;
  localparam logic [1:0] TSPC_CAP_FALL     = 2'h1;
  localparam logic [1:0] TSPC_CAP_BOTH     = 2'h2;

  // Reset values
  localparam logic [8:0]  TSPC_RST_CTRL  = 9'h000;
  localparam logic [15:0] TSPC_RST_CMPA  = 16'h0000;
  localparam logic [7:0]  TSPC_RST_CMPP  = 8'h00;
  localparam logic [1:0]  TSPC_RST_MASK  = 2'h0;

  // Bus phase states
  typedef enum logic [1:0] {
    TSPC_BUS_IDLE = 2'b01,
    TSPC_BUS_ACK  = 2'b10
  } tspc_bus_e;

  // Synchronised pin events
  typedef struct packed {
    logic ext_edge;
    logic io_rise;
    logic io_fall;
  } tspc_pin_ev_s;

  // Module state
  typedef struct packed {
    tspc_bus_e   bus;
    logic [31:0] rdata;
    logic [8:0]  ctrl;
    logic        run;
    logic        run_d;
    logic [15:0] counter;
    logic [15:0] cmpa;
    logic [7:0]  cmpp;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        pin_out;
  } tspc_state_s;

endpackage

// ---- verilog/tspc_pin_sync.sv ----
`timescale 1ns/1ps
// Two-flop synchronisers and edge detectors for both pins
module tspc_pin_sync
  import tspc_pkg::*;
(
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  // Raw pins
  input  wire logic   ext_clock_pin,
  input  wire logic   timer_io_pin,
  // Events
  output tspc_pin_ev_s events
);

  logic [2:0] ext_sh;
  logic [2:0] io_sh;

  // Stage 0 is read only by stage 1; edges compare stages 1 and 2
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_sh <= 3'h0;
      io_sh  <= 3'h0;
    end
    else
    begin
      ext_sh <= {ext_sh[1:0], ext_clock_pin};
      io_sh  <= {io_sh[1:0], timer_io_pin};
    end
  end

  // One pulse per qualifying edge
  always_comb
  begin
    events.ext_edge = ext_sh[1] & ~ext_sh[2]; // RL19
    events.io_rise  = io_sh[1] & ~io_sh[2];   // RL19
    events.io_fall  = ~io_sh[1] & io_sh[2];   // RL19
  end

endmodule

// ---- verilog/tspc_timer.sv ----
`timescale 1ns/1ps
// Single-pulse output and capture input timer with Avalon-MM slave
module tspc_timer
  import tspc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Pins
  input  wire logic        ext_clock_pin,
  input  wire logic        timer_io_pin,
  output logic             timer_io_out,
  output logic             timer_io_oe,
  // Interrupt
  output logic             irq
);

  tspc_state_s  st;
  tspc_state_s  next_st;
  tspc_pin_ev_s ev;

  logic [1:0] op_mode;
  logic [1:0] func;
  logic       pulse_mode;
  logic       capt_mode;
  logic       run_rise;
  logic       run_fall;
  logic       match_a;
  logic       match_p;
  logic       cap_edge;
  logic       wr_go;
  logic       rd_go;
  logic       b0;
  logic       b1;

  // Pin synchroniser
  tspc_pin_sync u_sync (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .ext_clock_pin (ext_clock_pin),
    .timer_io_pin  (timer_io_pin),
    .events        (ev)
  );

  // Decoded fields
  assign op_mode    = st.ctrl[TSPC_POS_MODE+:2];
  assign func       = st.ctrl[TSPC_POS_FUNC+:2];
  assign pulse_mode = (op_mode == TSPC_MODE_PULSE) &&
                      (func == TSPC_FUNC_SINGLE);  // RL1
  assign capt_mode  = (op_mode == TSPC_MODE_CAPTURE); // RL10
  assign run_rise   = st.run & ~st.run_d;
  assign run_fall   = ~st.run & st.run_d;
  assign match_a    = st.run && (st.counter == st.cmpa);
  // Top byte against P, low byte all ones; zero never matches so the counter wraps at 65536
  assign match_p    = st.run && (st.cmpp != 8'h00) &&
                      (st.counter[15:8] == st.cmpp) &&
                      (st.counter[7:0] == 8'hFF); // RL18

  // Active edge select; both bits high disables capture
  always_comb
  begin
    case (func)
      TSPC_CAP_RISE: cap_edge = ev.io_rise;            // RL11
      TSPC_CAP_FALL: cap_edge = ev.io_fall;            // RL11
      TSPC_CAP_BOTH: cap_edge = ev.io_rise | ev.io_fall; // RL11
      default:       cap_edge = 1'b0;                  // RL11
    endcase
  end

  // Bus handshake: one wait cycle, then acknowledge
  assign wr_go = avs_write && (st.bus == TSPC_BUS_ACK);
  assign rd_go = avs_read && (st.bus == TSPC_BUS_IDLE);
  assign b0    = avs_byteenable[0];
  assign b1    = avs_byteenable[1];
  assign avs_waitrequest = (avs_read | avs_write) &&
                           (st.bus == TSPC_BUS_IDLE);
  assign avs_readdata    = st.rdata;
  assign irq             = |(st.status & st.mask);
  assign timer_io_out    = st.pin_out;
  assign timer_io_oe     = pulse_mode;

  // Next-state logic
  always_comb
  begin
    next_st       = st;
    next_st.run_d = st.run;

    // Bus phase
    case (st.bus)
      TSPC_BUS_IDLE:
        if (avs_read | avs_write)
          next_st.bus = TSPC_BUS_ACK;
      TSPC_BUS_ACK:
        next_st.bus = TSPC_BUS_IDLE;
      default:
        next_st.bus = TSPC_BUS_IDLE;
    endcase

    // Read data latched in the wait cycle
    if (rd_go)
    begin
      case (avs_address)
        TSPC_OFS_CTRL:   next_st.rdata = {23'h0, st.ctrl};
        TSPC_OFS_RUN:    next_st.rdata = {31'h0, st.run};
        TSPC_OFS_CMPA:   next_st.rdata = {16'h0, st.cmpa};
        TSPC_OFS_CMPP:   next_st.rdata = {24'h0, st.cmpp};
        TSPC_OFS_COUNT:  next_st.rdata = {16'h0, st.counter};
        TSPC_OFS_STATUS: next_st.rdata = {30'h0, st.status};
        TSPC_OFS_MASK:   next_st.rdata = {30'h0, st.mask};
        default:         next_st.rdata = 32'h0;
      endcase
    end

    // Register writes
    if (wr_go)
    begin
      case (avs_address)
        TSPC_OFS_CTRL:
        begin
          if (b0)
            next_st.ctrl[7:0] = avs_writedata[7:0];
          if (b1)
            next_st.ctrl[8] = avs_writedata[8];
        end
        TSPC_OFS_RUN:
          if (b0)
            next_st.run = avs_writedata[0]; // RL2 RL12
        TSPC_OFS_CMPA:
        begin
          if (b0)
            next_st.cmpa[7:0] = avs_writedata[7:0];
          if (b1)
            next_st.cmpa[15:8] = avs_writedata[15:8];
        end
        TSPC_OFS_CMPP:
          if (b0)
            next_st.cmpp = avs_writedata[7:0];
        TSPC_OFS_STATUS:
          if (b0)
            next_st.status = st.status & ~avs_writedata[1:0];
        TSPC_OFS_MASK:
          if (b0)
            next_st.mask = avs_writedata[1:0];
        default:
          next_st.ctrl = st.ctrl;
      endcase
    end

    // Counter: loaded with 1 on run rising edge, advances while running
    if (run_rise)
      next_st.counter = 16'h0001; // RL7
    else if (st.run)
      next_st.counter = st.counter + 16'h0001; // RL14

    if (pulse_mode)
    begin
      // External pin edge sets run automatically
      if (ev.ext_edge)
        next_st.run = 1'b1; // RL3
      // Compare A ends the pulse; P, clear and swap unused
      if (match_a && !run_rise)
      begin
        next_st.run = 1'b0;                // RL6
        next_st.status[TSPC_ST_A] = 1'b1;  // RL6
      end
      // Output follows run, level bit sets active sense
      next_st.pin_out = (next_st.run ~^ st.ctrl[TSPC_POS_LEVEL]) ^
                        st.ctrl[TSPC_POS_INV]; // RL4 RL5 RL8
    end
    else
      next_st.pin_out = 1'b0;

    if (capt_mode)
    begin
      // Pin input watched regardless of its direction
      if (cap_edge && st.run)
      begin
        next_st.cmpa = st.counter;          // RL13 RL16
        next_st.status[TSPC_ST_A] = 1'b1;   // RL13
      end
      // Compare P wraps the counter; output bits ignored
      if (match_p && !run_rise)
      begin
        next_st.counter = 16'h0000;         // RL15 RL17
        next_st.status[TSPC_ST_P] = 1'b1;   // RL15
      end
    end

    // Stop leaves the counter at its residual value
    if (run_fall)
      next_st.counter = st.counter; // RL14
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.bus     <= TSPC_BUS_IDLE;
      st.rdata   <= 32'h0;
      st.ctrl    <= TSPC_RST_CTRL;
      st.run     <= 1'b0;
      st.run_d   <= 1'b0;
      st.counter <= 16'h0000;
      st.cmpa    <= TSPC_RST_CMPA;
      st.cmpp    <= TSPC_RST_CMPP;
      st.status  <= 2'h0;
      st.mask    <= TSPC_RST_MASK;
      st.pin_out <= 1'b0;
    end
    else
      st <= next_st;
  end

endmodule

// ---- test/tspc_timer_sva.sv ----
`timescale 1ns/1ps
// Port checker for the timer
module tspc_timer_sva
  import tspc_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins and interrupt
  input wire logic        ext_clock_pin,
  input wire logic        timer_io_out,
  input wire logic        timer_io_oe,
  input wire logic        irq
);
  logic [8:0] ctrl;
  logic [1:0] mask;
  logic       wdone;
  logic       rq;
  // Completed write and any request
  assign wdone = avs_write && !avs_waitrequest;
  assign rq = avs_read || avs_write;
  // Shadow copies of control and mask
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl <= 9'h000;
      mask <= 2'h0;
    end
    else if (wdone && avs_address == 5'h00)
      ctrl <= avs_writedata[8:0];
    else if (wdone && avs_address == 5'h18)
      mask <= avs_writedata[1:0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence ext_rise;
    $rose(ext_clock_pin);
  endsequence
  sequence pulse_on;
    timer_io_out == (ctrl[3] ^ ctrl[2]);
  endsequence
  a_wait_first: assert property ($rose(rq) |-> avs_waitrequest)
    else $error("no wait on new request");
  a_wait_one: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  a_rdata_hold: assert property ($changed(avs_readdata)
    |-> avs_read && !avs_waitrequest)
    else $error("read data moved outside a read");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest
    && avs_address > 5'h18 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_oe_single: assert property (ctrl[7:6] == TSPC_MODE_PULSE
    && ctrl[5:4] == TSPC_FUNC_SINGLE |-> timer_io_oe)
    else $error("pin not driven in single pulse");
  a_oe_capture: assert property (
    ctrl[7:6] == TSPC_MODE_CAPTURE |-> !timer_io_oe)
    else $error("pin driven in capture");
  a_irq_masked: assert property (irq |-> mask != 2'h0)
    else $error("interrupt while masked");
  a_ext_start: assert property (ctrl[7:6] == TSPC_MODE_PULSE
    && ctrl[5:4] == TSPC_FUNC_SINGLE ##0 ext_rise |-> ##[1:8] pulse_on)
    else $error("external edge gave no pulse");
endmodule

bind tspc_timer tspc_timer_sva chk (.sys_clk, .rst_n, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .ext_clock_pin, .timer_io_out, .timer_io_oe, .irq);

// ---- test/tspc_pins.sv ----
`timescale 1ns/1ps
// Far-side pin driver for trigger and capture sources
module tspc_pins
(
  // Clock
  input  wire logic sys_clk,
  // Pins
  output logic      ext_clock_pin,
  output logic      timer_io_pin
);
  // Pins idle low
  initial
  begin
    ext_clock_pin = 1'b0;
    timer_io_pin = 1'b0;
  end
  // Hold each level past the synchroniser delay
  task automatic drive(input logic e, input logic t);
    @(posedge sys_clk);
    ext_clock_pin <= e;
    timer_io_pin <= t;
    repeat (5) @(posedge sys_clk);
  endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the timer
module tb;
  logic        sys_clk, rst_n, rd, wr, ext, pin_io, io_wire;
  logic        io_out, io_oe, irq, wait_r;
  logic [4:0]  addr;
  logic [31:0] wd, rdata, q;
  int          n_mismatch, samples_checked;
  // Wire level from both drivers
  assign io_wire = io_oe ? io_out : pin_io;
  tspc_pins pins (.sys_clk(sys_clk), .ext_clock_pin(ext),
    .timer_io_pin(pin_io));
  tspc_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(wait_r), .ext_clock_pin(ext),
    .timer_io_pin(io_wire), .timer_io_out(io_out), .timer_io_oe(io_oe),
    .irq(irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wait_r !== 1'b0 && n < 16);
    if (n >= 16)
      n_mismatch++;
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task test_done;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Reset values and an unmapped place
  task automatic t_reset;
    logic [4:0] a [5] = '{5'h00, 5'h08, 5'h0C, 5'h18, 5'h1C};
    foreach (a[i])
    begin
      bus(1'b0, a[i], 32'h0);
      chk(q, 32'h0);
    end
  endtask
  // Software pulse, width set by compare A
  task automatic t_pulse;
    int w;
    bus(1'b1, 5'h00, 32'hB8);
    bus(1'b1, 5'h08, 32'h14);
    bus(1'b1, 5'h18, 32'h1);
    bus(1'b1, 5'h04, 32'h1);
    w = 0;
    repeat (60)
    begin
      @(posedge sys_clk);
      if (io_wire === 1'b1)
        w++;
    end
    chk(w >= 20 && w <= 22, 1'b1);
    bus(1'b0, 5'h04, 32'h0);
    chk(q, 32'h0);
    chk(irq, 1'b1);
    bus(1'b1, 5'h14, 32'h1);
    bus(1'b0, 5'h10, 32'h0);
    chk(q != 32'h0, 1'b1);
    chk(irq, 1'b0);
  endtask
  // External pin edge starts the pulse
  task automatic t_ext;
    int h;
    pins.drive(1'b1, 1'b0);
    h = 0;
    repeat (20)
    begin
      @(posedge sys_clk);
      if (io_wire === 1'b1)
        h = 1;
    end
    chk(h, 1);
    pins.drive(1'b0, 1'b0);
    repeat (30) @(posedge sys_clk);
  endtask
  // Every edge selection, capture into compare A
  task automatic t_capture;
    logic [1:0] hit [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
    logic [31:0] c;
    bus(1'b1, 5'h04, 32'h0);
    bus(1'b1, 5'h00, 32'h40);
    bus(1'b1, 5'h14, 32'h3);
    bus(1'b1, 5'h04, 32'h1);
    for (int f = 0; f < 4; f++)
    begin
      bus(1'b1, 5'h00, 32'h40 | (f << 4));
      pins.drive(1'b0, 1'b1);
      bus(1'b0, 5'h14, 32'h0);
      chk(q[0], hit[f][1]);
      bus(1'b1, 5'h14, 32'h1);
      pins.drive(1'b0, 1'b0);
      bus(1'b0, 5'h14, 32'h0);
      chk(q[0], hit[f][0]);
      bus(1'b1, 5'h14, 32'h1);
    end
    bus(1'b0, 5'h08, 32'h0);
    chk(q[15:0] != 16'h0, 1'b1);
    bus(1'b0, 5'h10, 32'h0);
    c = q;
    bus(1'b0, 5'h10, 32'h0);
    chk(q > c, 1'b1);
  endtask
  // Compare P limits the count
  task automatic t_period;
    logic [31:0] c;
    bus(1'b1, 5'h04, 32'h0);
    bus(1'b1, 5'h0C, 32'h1);
    bus(1'b1, 5'h14, 32'h3);
    bus(1'b1, 5'h04, 32'h1);
    repeat (600) @(posedge sys_clk);
    bus(1'b0, 5'h14, 32'h0);
    chk(q[1], 1'b1);
    bus(1'b0, 5'h10, 32'h0);
    chk(q < 32'h200, 1'b1);
    bus(1'b1, 5'h04, 32'h0);
    bus(1'b0, 5'h10, 32'h0);
    c = q;
    bus(1'b0, 5'h10, 32'h0);
    chk(q, c);
  endtask
  // Clock at 50 ns
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
  // Main sequence
  initial
  begin
    {rst_n, rd, wr, addr, wd} = '0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_pulse();
    t_ext();
    t_capture();
    t_period();
    test_done();
  end
endmodule
